// ---- rtl/sbsum_consts.svh ----
/*
 * Bit positions, masks and reset values of the status byte summary logic.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef SBSUM_CONSTS_SVH
`define SBSUM_CONSTS_SVH

// Function
// - Bit 2 is set while the error queue is not empty (errq_not_empty_i).
// - With mask bit 2 set, every new error entry raises a service request.
// - Bit 3 is the OR of questionable events ANDed with their enables.
// - Bit 4 is set only while the output buffer holds readable data.
// - Bit 5 is the OR of event status bits ANDed with their enables.
// - Bit 6 is set when any other bit is set with its mask bit.
// - Bit 7 is the OR of operation events ANDed with their enables.
// - Mask bit 6 is ignored for the master summary and service request.
// - A masked status bit rising from 0 to 1 raises a service request.
// - Reading an event part clears it; condition and enable are untouched.
// - Status byte query and serial poll both return the current value.

// ----------------------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------------------
`define SBSUM_BIT_ERRQ   2
`define SBSUM_BIT_QUEST  3
`define SBSUM_BIT_OUTPEND 4
`define SBSUM_BIT_EVSUM  5
`define SBSUM_BIT_MASTER 6
`define SBSUM_BIT_OPER   7

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define SBSUM_MASTER_IGNORE 8'hBF
`define SBSUM_MASK_RESET   8'h00
`define SBSUM_BYTE_RESET   8'h00
`define SBSUM_GRP_WIDTH    16

`endif

// ---- rtl/sbsum_pkg.sv ----
/*
 * Types of the status byte summary logic.
 * Assumes sbsum_consts.svh is on the include path.
 */
`include "sbsum_consts.svh"

package sbsum_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic [7:0]                   sbsum_byte_t;
    typedef logic [`SBSUM_GRP_WIDTH-1:0]  sbsum_grp_t;

endpackage

// ---- rtl/sbsum_group_reg.sv ----
/*
 * One status register group: condition edge filters, event part with
 * clear on read, enable gating and the sum bit.
 * Assumes condition, filter and enable inputs come from ref_clk_i logic.
 */
`timescale 1ns/1ps
`default_nettype none

module sbsum_group_reg #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    // Group parts
    input  wire logic [W-1:0]  cond_i,
    input  wire logic [W-1:0]  ptr_i,
    input  wire logic [W-1:0]  ntr_i,
    input  wire logic [W-1:0]  enable_i,
    // Event read port
    input  wire logic          rd_i,
    output logic      [W-1:0]  rdata_o,
    // Sum bit
    output logic               sum_o
);

    logic [W-1:0]  cond_prev_ff;
    logic [W-1:0]  event_ff;
    logic [W-1:0]  rdata_ff;
    logic [W-1:0]  nxt_cond_prev;
    logic [W-1:0]  nxt_event;
    logic [W-1:0]  nxt_rdata;
    logic [W-1:0]  set_bits;

    // ------------------------------------------------------------------------
    // Event part
    // ------------------------------------------------------------------------
    always_comb begin
        set_bits = (cond_i & ~cond_prev_ff & ptr_i)
                 | (~cond_i & cond_prev_ff & ntr_i);
        set_bits[W-1] = 1'b0;
        nxt_cond_prev = cond_i;
        nxt_event = rd_i ? '0 : event_ff;
        nxt_event = nxt_event | set_bits;  // Set wins over read clear
        nxt_rdata = rd_i ? event_ff : rdata_ff;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cond_prev_ff <= '0;
            event_ff     <= '0;
            rdata_ff     <= '0;
        end else begin
            cond_prev_ff <= nxt_cond_prev;
            event_ff     <= nxt_event;
            rdata_ff     <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;
    assign sum_o   = |(event_ff & enable_i);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_EVENT_CLEAR_ON_READ: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_i && (set_bits == '0) |=> (event_ff == '0) &&
                                     (rdata_ff == $past(event_ff)))
        else $error("event part not cleared by read");

endmodule

`default_nettype wire

// ---- rtl/sbsum_top.sv ----
/*
 * Status byte summary logic: error queue, questionable, output pending,
 * event summary, master summary and operation bits, service request mask
 * and the service request with serial poll.
 * Assumes all inputs come from logic on ref_clk_i; bits 0 and 1 read zero.
 */
`timescale 1ns/1ps
`default_nettype none

`include "sbsum_consts.svh"

module sbsum_top #(
    parameter int GW = `SBSUM_GRP_WIDTH
) (
    // Clock and reset
    input  wire logic           ref_clk_i,
    input  wire logic           rst_i,
    // Error queue
    input  wire logic           errq_push_i,
    input  wire logic           errq_not_empty_i,
    // Questionable group
    input  wire logic [GW-1:0]  quest_cond_i,
    input  wire logic [GW-1:0]  quest_ptr_i,
    input  wire logic [GW-1:0]  quest_ntr_i,
    input  wire logic [GW-1:0]  quest_enable_i,
    input  wire logic           quest_rd_i,
    output logic      [GW-1:0]  quest_event_o,
    // Operation group
    input  wire logic [GW-1:0]  oper_cond_i,
    input  wire logic [GW-1:0]  oper_ptr_i,
    input  wire logic [GW-1:0]  oper_ntr_i,
    input  wire logic [GW-1:0]  oper_enable_i,
    input  wire logic           oper_rd_i,
    output logic      [GW-1:0]  oper_event_o,
    // Event status register and enable
    input  wire logic [7:0]     esr_i,
    input  wire logic [7:0]     ese_i,
    // Output buffer
    input  wire logic           output_pending_i,
    // Service request mask
    input  wire logic           mask_wr_i,
    input  wire logic [7:0]     mask_wdata_i,
    output logic      [7:0]     service_request_mask_o,
    // Status byte read
    input  wire logic           byte_query_i,
    input  wire logic           serial_poll_i,
    output logic      [7:0]     summary_status_byte_o,
    // Service request
    output logic                service_req_o
);

    // ------------------------------------------------------------------------
    // Masked OR
    // ------------------------------------------------------------------------
    function automatic logic masked_or(input logic [7:0] v,
                                       input logic [7:0] m);
        masked_or = |(v & m);
    endfunction

    sbsum_pkg::sbsum_byte_t  mask_ff;
    sbsum_pkg::sbsum_byte_t  byte_prev_ff;
    sbsum_pkg::sbsum_byte_t  byte_rd_ff;
    logic                    srq_ff;
    sbsum_pkg::sbsum_byte_t  nxt_mask;
    sbsum_pkg::sbsum_byte_t  nxt_byte_prev;
    sbsum_pkg::sbsum_byte_t  nxt_byte_rd;
    logic                    nxt_srq;
    sbsum_pkg::sbsum_byte_t  byte_base;
    sbsum_pkg::sbsum_byte_t  byte_now;
    sbsum_pkg::sbsum_byte_t  mask_eff;
    logic                    quest_sum;
    logic                    oper_sum;
    logic                    event_summary_flag;
    logic                    master_summary_flag;
    logic                    new_req;

    // ------------------------------------------------------------------------
    // Lower groups
    // ------------------------------------------------------------------------
    sbsum_group_reg #(
        .W (GW)
    ) u_quest (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .cond_i    (quest_cond_i),
        .ptr_i     (quest_ptr_i),
        .ntr_i     (quest_ntr_i),
        .enable_i  (quest_enable_i),
        .rd_i      (quest_rd_i),
        .rdata_o   (quest_event_o),
        .sum_o     (quest_sum)
    );

    sbsum_group_reg #(
        .W (GW)
    ) u_oper (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .cond_i    (oper_cond_i),
        .ptr_i     (oper_ptr_i),
        .ntr_i     (oper_ntr_i),
        .enable_i  (oper_enable_i),
        .rd_i      (oper_rd_i),
        .rdata_o   (oper_event_o),
        .sum_o     (oper_sum)
    );

    // ------------------------------------------------------------------------
    // Summary bits, recomputed every cycle
    // ------------------------------------------------------------------------
    always_comb begin
        event_summary_flag = masked_or(esr_i, ese_i);
        mask_eff = mask_ff & `SBSUM_MASTER_IGNORE;
        byte_base = `SBSUM_BYTE_RESET;
        byte_base[`SBSUM_BIT_ERRQ]    = errq_not_empty_i;
        byte_base[`SBSUM_BIT_QUEST]   = quest_sum;
        byte_base[`SBSUM_BIT_OUTPEND] = output_pending_i;
        byte_base[`SBSUM_BIT_EVSUM]   = event_summary_flag;
        byte_base[`SBSUM_BIT_OPER]    = oper_sum;
        master_summary_flag = masked_or(byte_base, mask_eff);
        byte_now = byte_base;
        byte_now[`SBSUM_BIT_MASTER] = master_summary_flag;
    end

    // ------------------------------------------------------------------------
    // Mask, read data and service request
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_mask = mask_wr_i ? mask_wdata_i : mask_ff;
        nxt_byte_prev = byte_now;
        nxt_byte_rd = byte_rd_ff;
        if (byte_query_i || serial_poll_i) begin
            nxt_byte_rd = byte_now;
        end
        new_req = masked_or(byte_now & ~byte_prev_ff,
                            mask_eff);
        new_req = new_req
               || (errq_push_i && mask_eff[`SBSUM_BIT_ERRQ]);
        nxt_srq = serial_poll_i ? 1'b0 : srq_ff;
        nxt_srq = nxt_srq | new_req;                 // New request wins
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_ff      <= `SBSUM_MASK_RESET;
            byte_prev_ff <= `SBSUM_BYTE_RESET;
            byte_rd_ff   <= `SBSUM_BYTE_RESET;
            srq_ff       <= 1'b0;
        end else begin
            mask_ff      <= nxt_mask;
            byte_prev_ff <= nxt_byte_prev;
            byte_rd_ff   <= nxt_byte_rd;
            srq_ff       <= nxt_srq;
        end
    end

    assign service_request_mask_o = mask_ff;
    assign summary_status_byte_o  = byte_rd_ff;
    assign service_req_o          = srq_ff;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_ERRQ_BIT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        byte_query_i |=> byte_rd_ff[2] == $past(errq_not_empty_i))
        else $error("error queue bit wrong");

    AST_ERRQ_SRQ: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        errq_push_i && mask_ff[2] |=> service_req_o)
        else $error("error entry did not request service");

    AST_QUEST_BIT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        serial_poll_i |=> byte_rd_ff[3] == $past(quest_sum))
        else $error("questionable bit wrong");

    AST_OUTPEND_BIT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        byte_query_i && !output_pending_i |=> !summary_status_byte_o[4])
        else $error("output pending bit set without data");

    AST_EVSUM_BIT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        byte_query_i |=> byte_rd_ff[5] == $past(|(esr_i & ese_i)))
        else $error("event summary bit wrong");

    AST_MASTER_BIT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        byte_query_i |=> byte_rd_ff[6] ==
            |(byte_rd_ff & $past(mask_ff) & `SBSUM_MASTER_IGNORE))
        else $error("master summary bit wrong");

    AST_MASK6_IGNORED: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        mask_ff == 8'h40 |-> !master_summary_flag)
        else $error("mask bit 6 affected master summary");

    AST_OPER_BIT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        serial_poll_i |=> byte_rd_ff[7] == $past(oper_sum))
        else $error("operation bit wrong");

    AST_SRQ_ON_RISE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(byte_now[3]) && mask_ff[3] |=> service_req_o)
        else $error("rising masked bit did not request service");

    AST_SRQ_ON_PEND_RISE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(byte_now[4]) && mask_ff[4] |=> service_req_o)
        else $error("rising pending bit did not request service");

    AST_POLL_CLEARS: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        serial_poll_i && !new_req |=> !service_req_o ##1
            (service_req_o == $past(new_req)))
        else $error("serial poll did not clear service request");

    AST_MASK_IMMEDIATE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        mask_wr_i ##[1:2] byte_query_i |=>
            byte_rd_ff[6] == |($past(byte_base, 1) & $past(mask_ff)
                               & `SBSUM_MASTER_IGNORE))
        else $error("mask change did not act at once");

    COV_ERRQ_SRQ: cover property (
        @(posedge ref_clk_i) disable iff (rst_i)
        errq_push_i && mask_ff[2] ##1 service_req_o ##[1:20] serial_poll_i);

    COV_OUTPEND_QUERY: cover property (
        @(posedge ref_clk_i) disable iff (rst_i)
        output_pending_i && byte_query_i);

    COV_OPER_SRQ: cover property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(oper_sum) && mask_ff[7]);

    COV_QUEST_READ: cover property (
        @(posedge ref_clk_i) disable iff (rst_i)
        quest_sum ##1 quest_rd_i);

endmodule

`default_nettype wire

// ---- sim/sbsum_ctrl_model.sv ----
/*
 * Behavioural model of the remote bus controller: status byte query,
 * serial poll and an optional automatic poll on each service request.
 * Assumes the device samples requests on the rising ref_clk_i edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sbsum_ctrl_model (
    // Clock
    input  wire logic        ref_clk_i,
    // From the device
    input  wire logic        service_req_i,
    input  wire logic [7:0]  status_byte_i,
    // To the device
    output logic             byte_query_o,
    output logic             serial_poll_o
);
    logic auto_poll = 1'b0;
    int   poll_gap  = 3;

    initial begin
        byte_query_o  = 1'b0;
        serial_poll_o = 1'b0;
    end

    // ------------------------------------------------------------------------
    // Status byte access
    // ------------------------------------------------------------------------
    task automatic query(output logic [7:0] v);
        @(negedge ref_clk_i);
        byte_query_o = 1'b1;
        @(negedge ref_clk_i);
        byte_query_o = 1'b0;
        v = status_byte_i;
    endtask

    task automatic poll(output logic [7:0] v);
        @(negedge ref_clk_i);
        serial_poll_o = 1'b1;
        @(negedge ref_clk_i);
        serial_poll_o = 1'b0;
        v = status_byte_i;
    endtask

    // Polls after each request, as a slow controller would
    always @(negedge ref_clk_i) begin
        if (auto_poll && service_req_i === 1'b1) begin
            repeat (poll_gap) @(negedge ref_clk_i);
            serial_poll_o = 1'b1;
            @(negedge ref_clk_i);
            serial_poll_o = 1'b0;
        end
    end
endmodule

`default_nettype wire

// ---- sim/sbsum_top_tb.sv ----
/*
 * Self-checking testbench of the status byte summary logic.
 * Assumes the controller model drives query and poll requests.
 */
`timescale 1ns/1ps
`default_nettype none

module sbsum_top_tb;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        push      = 1'b0;
    logic        not_empty = 1'b0;
    logic [15:0] cnd [2]   = '{16'h0000, 16'h0000};
    logic [15:0] ptr [2]   = '{16'h0000, 16'h0000};
    logic [15:0] ntr [2]   = '{16'h0000, 16'h0000};
    logic [15:0] enb [2]   = '{16'h0000, 16'h0000};
    logic        rd  [2]   = '{1'b0, 1'b0};
    logic [15:0] evo [2];
    logic [7:0]  esr       = 8'h00;
    logic [7:0]  ese       = 8'h00;
    logic        pending   = 1'b0;
    logic        m_wr      = 1'b0;
    logic [7:0]  m_wd      = 8'h00;
    logic [7:0]  mask;
    logic        qry;
    logic        spl;
    logic [7:0]  sbyte;
    logic        srq;
    logic [7:0]  v;
    int          n_fail     = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    sbsum_top #(.GW(16)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .errq_push_i(push), .errq_not_empty_i(not_empty),
        .quest_cond_i(cnd[0]), .quest_ptr_i(ptr[0]), .quest_ntr_i(ntr[0]),
        .quest_enable_i(enb[0]), .quest_rd_i(rd[0]),
        .quest_event_o(evo[0]),
        .oper_cond_i(cnd[1]), .oper_ptr_i(ptr[1]), .oper_ntr_i(ntr[1]),
        .oper_enable_i(enb[1]), .oper_rd_i(rd[1]), .oper_event_o(evo[1]),
        .esr_i(esr), .ese_i(ese), .output_pending_i(pending),
        .mask_wr_i(m_wr), .mask_wdata_i(m_wd),
        .service_request_mask_o(mask),
        .byte_query_i(qry), .serial_poll_i(spl),
        .summary_status_byte_o(sbyte), .service_req_o(srq)
    );

    sbsum_ctrl_model ctl (
        .ref_clk_i(ref_clk_i), .service_req_i(srq), .status_byte_i(sbyte),
        .byte_query_o(qry), .serial_poll_o(spl)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] s,
                       input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic set_mask(input logic [7:0] m);
        @(negedge ref_clk_i);
        m_wr = 1'b1;
        m_wd = m;
        @(negedge ref_clk_i);
        m_wr = 1'b0;
    endtask

    // Waits up to four cycles for the expected request level, then four more when it is low
    task automatic srq_is(input string nm, input logic e);
        int k;
        for (k = 0; k < 4 && srq !== e; k++) @(negedge ref_clk_i);
        if (e === 1'b0) repeat (4) @(negedge ref_clk_i);
        chk(nm, {15'h0000, srq}, {15'h0000, e});
    endtask

    task automatic grp(input int g, input int b);
        logic [7:0] bm;
        bm = (g == 0) ? 8'h08 : 8'h80;
        @(negedge ref_clk_i);
        ptr[g] = 16'h0001 << b;
        enb[g] = 16'h0001 << b;
        cnd[g] = 16'h0001 << b;
        repeat (2) @(negedge ref_clk_i);
        ctl.query(v);
        chk("sum_set", v & bm, bm);
        rd[g] = 1'b1;
        @(negedge ref_clk_i);
        rd[g] = 1'b0;
        chk("event_rd", evo[g], 16'h0001 << b);
        ctl.query(v);
        chk("sum_clr", v & bm, 8'h00);
        ntr[g] = 16'h0001 << b;
        cnd[g] = 16'h0000;
        repeat (2) @(negedge ref_clk_i);
        ctl.query(v);
        chk("neg_edge", v & bm, bm);
        enb[g] = 16'h0000;
        ctl.query(v);
        chk("enable_off", v & bm, 8'h00);
        rd[g] = 1'b1;
        @(negedge ref_clk_i);
        rd[g] = 1'b0;
        ptr[g] = 16'h0000;
        ntr[g] = 16'h0000;
    endtask

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (6) @(negedge ref_clk_i);
        rst_i = 1'b0;
        ctl.query(v);
        chk("reset_byte", v, 8'h00);
        chk("reset_mask", mask, 8'h00);
        chk("reset_srq", srq, 1'b0);
        for (int g = 0; g < 2; g++) begin
            grp(g, 0);
            grp(g, 14);
        end
        for (int i = 0; i < 8; i++) begin
            esr = 8'h01 << i;
            ese = 8'h01 << i;
            ctl.query(v);
            chk("evsum_on", v, 8'h20);
            ese = ~(8'h01 << i);
            ctl.query(v);
            chk("evsum_off", v, 8'h00);
        end
        esr = 8'h00;
        pending = 1'b1;
        ctl.query(v);
        chk("pend_query", v, 8'h10);
        ctl.poll(v);
        chk("pend_poll", v, 8'h10);
        pending = 1'b0;
        set_mask(8'h10);
        chk("mask_wr", mask, 8'h10);
        pending = 1'b1;
        srq_is("srq_rise", 1'b1);
        ctl.query(v);
        chk("master_on", v, 8'h50);
        ctl.poll(v);
        chk("poll_byte", v, 8'h50);
        srq_is("srq_once", 1'b0);
        set_mask(8'h00);
        ctl.query(v);
        chk("master_mask_off", v, 8'h10);
        pending = 1'b0;
        ctl.query(v);
        chk("pend_gone", v, 8'h00);
        set_mask(8'h40);
        pending = 1'b1;
        srq_is("mask6_srq", 1'b0);
        ctl.query(v);
        chk("mask6_master", v, 8'h10);
        pending = 1'b0;
        set_mask(8'h04);
        for (int n = 0; n < 2; n++) begin
            @(negedge ref_clk_i);
            push = 1'b1;
            not_empty = 1'b1;
            @(negedge ref_clk_i);
            push = 1'b0;
            srq_is("errq_srq", 1'b1);
            ctl.query(v);
            chk("errq_byte", v, 8'h44);
            ctl.poll(v);
            srq_is("errq_poll", 1'b0);
        end
        set_mask(8'h0C);
        ptr[0] = 16'h0001;
        enb[0] = 16'h0001;
        cnd[0] = 16'h0001;
        srq_is("quest_srq", 1'b1);
        ctl.poll(v);
        chk("quest_poll", v, 8'h4C);
        srq_is("quest_poll_srq", 1'b0);
        ctl.auto_poll = 1'b1;
        @(negedge ref_clk_i);
        push = 1'b1;
        @(negedge ref_clk_i);
        push = 1'b0;
        srq_is("auto_srq", 1'b1);
        repeat (8) @(negedge ref_clk_i);
        chk("auto_poll", srq, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
